// >>> dual_timer.sv
// Two timer/counters with external interrupt flag logic behind an AHB-Lite slave.
//
// Notes on behaviour
// - Timer1 overflow sets flag; vector acknowledge clears it.
// - Timer0 overflow sets flag; vector acknowledge clears it.
// - Timer1 counts only while its run bit set.
// - Timer0 counts only while its run bit set.
// - Interrupt-1 falling edge sets flag; acknowledge clears.
// - Interrupt-0 falling edge sets flag; acknowledge clears.
// - Interrupt-1 select: 0 low level, 1 falling edge.
// - Interrupt-0 select: 0 low level, 1 falling edge.
// - Timer1 gating also needs interrupt-1 pin high.
// - Timer0 gating also needs interrupt-0 pin high.
// - Timer1 ticks every two clocks or pin falls.
// - Timer0 ticks every two clocks or pin falls.
// - Timer1 modes: prescaled 13-bit, 16-bit, stopped.
// - Timer1 reload mode: low byte reloads from high.
// - Timer0 modes: prescaled 13-bit and 16-bit.
// - Timer0 reload mode: low byte reloads from high.
// - Timer0 split: high byte uses Timer1 run, flag.
// - Four count bytes read, written, reset to zero.
// - Mode, gating, select fields reset to zero.
`timescale 1ns/1ps
module dual_timer (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // External pins.
  input  wire logic        timer0CountPin,
  input  wire logic        timer1CountPin,
  input  wire logic        extInterrupt0Pin,
  input  wire logic        extInterrupt1Pin,
  // Vector acknowledges from the CPU interrupt logic.
  input  wire logic        timer0VectorAck,
  input  wire logic        timer1VectorAck,
  input  wire logic        extInt0VectorAck,
  input  wire logic        extInt1VectorAck,
  // Interrupt requests towards the CPU interrupt logic.
  output logic             timer0IntRequest,
  output logic             timer1IntRequest,
  output logic             extInt0IntRequest,
  output logic             extInt1IntRequest
);
  import dual_timer_pkg::*;

  // ==========================================================================
  // Helpers.
  function automatic logic [8:0] incByte(input logic [7:0] value);
    incByte = {1'b0, value} + 9'h001;
  endfunction

  function automatic logic hitIndex(input logic [29:0] wordAddr, input logic [29:0] idx);
    hitIndex = (wordAddr == idx);
  endfunction

  function automatic logic prescaleWrap(input logic [7:0] value);
    prescaleWrap = &value[PRESCALE_BITS-1:0];
  endfunction

  // ==========================================================================
  // Register state.
  logic        timer1_overflow_flag_ff;
  logic        timer1_run_ff;
  logic        timer0_overflow_flag_ff;
  logic        timer0_run_ff;
  logic        ext_ext_interrupt1_pin_edge_flag_ff;
  logic        ext_ext_interrupt1_pin_trigger_select_ff;
  logic        ext_ext_interrupt0_pin_edge_flag_ff;
  logic        ext_ext_interrupt0_pin_trigger_select_ff;
  logic [7:0]  timer_mode_select_ff;
  logic [7:0]  timer0_count_low_ff;
  logic [7:0]  timer0_count_high_ff;
  logic [7:0]  timer1_count_low_ff;
  logic [7:0]  timer1_count_high_ff;

  // ==========================================================================
  // Pin synchronisers; index 0..3 are timer0, timer1, interrupt0, interrupt1.
  logic [3:0]  pinMeta_ff;
  logic [3:0]  pinSync_ff;
  logic [3:0]  pinPrev_ff;
  logic [3:0]  pinFall;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_ff <= 4'hf;
      pinSync_ff <= 4'hf;
      pinPrev_ff <= 4'hf;
    end else begin
      pinMeta_ff <= {extInterrupt1Pin, extInterrupt0Pin, timer1CountPin, timer0CountPin};
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinSync_ff;
    end
  end

  // One pulse per edge, since each sample pair is compared only once.
  assign pinFall = pinPrev_ff & ~pinSync_ff;

  // ==========================================================================
  // Timer tick: free-running divider, one tick every two clocks.
  logic [0:0]  tickPhase_ff;
  logic        timerTick;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tickPhase_ff <= 1'h0;
    end else begin
      tickPhase_ff <= tickPhase_ff + 1'h1;
    end
  end

  assign timerTick = (tickPhase_ff == TICK_LAST);

  // ==========================================================================
  // Mode fields and count enables.
  timer_mode_t mode0;
  timer_mode_t mode1;
  logic        enable0;
  logic        enable1;
  logic        step0;
  logic        step1;

  assign mode0 = timer_mode_t'(timer_mode_select_ff[MSB_T0_MODE:LSB_T0_MODE]);
  assign mode1 = timer_mode_t'(timer_mode_select_ff[MSB_T1_MODE:LSB_T1_MODE]);

  assign enable0 = timer0_run_ff
                   & (~timer_mode_select_ff[BIT_T0_GATE] | pinSync_ff[2]);
  assign enable1 = timer1_run_ff
                   & (~timer_mode_select_ff[BIT_T1_GATE] | pinSync_ff[3]);

  assign step0 = enable0 & (timer_mode_select_ff[BIT_T0_CNT] ? pinFall[0] : timerTick);
  assign step1 = enable1 & (timer_mode_select_ff[BIT_T1_CNT] ? pinFall[1] : timerTick);

  // ==========================================================================
  // Timer0 next state.
  logic [7:0]  nxt_timer0Low;
  logic [7:0]  nxt_timer0High;
  logic        overflow0;
  logic        overflowSplit;

  always_comb begin
    logic [8:0] lowSum;
    logic [8:0] highSum;
    lowSum         = incByte(timer0_count_low_ff);
    highSum        = incByte(timer0_count_high_ff);
    nxt_timer0Low  = timer0_count_low_ff;
    nxt_timer0High = timer0_count_high_ff;
    overflow0      = 1'b0;
    overflowSplit  = 1'b0;
    case (mode0)
      MODE_PRESCALED: begin
        if (step0) begin
          nxt_timer0Low[PRESCALE_BITS-1:0] = lowSum[PRESCALE_BITS-1:0];
          if (prescaleWrap(timer0_count_low_ff)) begin
            nxt_timer0High = highSum[7:0];
            overflow0      = highSum[8];
          end
        end
      end
      MODE_WIDE16: begin
        if (step0) begin
          nxt_timer0Low = lowSum[7:0];
          if (lowSum[8]) begin
            nxt_timer0High = highSum[7:0];
            overflow0      = highSum[8];
          end
        end
      end
      MODE_RELOAD8: begin
        if (step0) begin
          nxt_timer0Low = lowSum[8] ? timer0_count_high_ff : lowSum[7:0];
          overflow0     = lowSum[8];
        end
      end
      MODE_SPLIT: begin
        if (step0) begin
          nxt_timer0Low = lowSum[7:0];
          overflow0     = lowSum[8];
        end
        // The high byte always times clocks and follows Timer1's run bit.
        if (timer1_run_ff && timerTick) begin
          nxt_timer0High = highSum[7:0];
          overflowSplit  = highSum[8];
        end
      end
      default: nxt_timer0Low = timer0_count_low_ff;
    endcase
  end

  // ==========================================================================
  // Timer1 next state.
  logic [7:0]  nxt_timer1Low;
  logic [7:0]  nxt_timer1High;
  logic        overflow1;

  always_comb begin
    logic [8:0] lowSum;
    logic [8:0] highSum;
    lowSum         = incByte(timer1_count_low_ff);
    highSum        = incByte(timer1_count_high_ff);
    nxt_timer1Low  = timer1_count_low_ff;
    nxt_timer1High = timer1_count_high_ff;
    overflow1      = 1'b0;
    case (mode1)
      MODE_PRESCALED: begin
        if (step1) begin
          nxt_timer1Low[PRESCALE_BITS-1:0] = lowSum[PRESCALE_BITS-1:0];
          if (prescaleWrap(timer1_count_low_ff)) begin
            nxt_timer1High = highSum[7:0];
            overflow1      = highSum[8];
          end
        end
      end
      MODE_WIDE16: begin
        if (step1) begin
          nxt_timer1Low = lowSum[7:0];
          if (lowSum[8]) begin
            nxt_timer1High = highSum[7:0];
            overflow1      = highSum[8];
          end
        end
      end
      MODE_RELOAD8: begin
        if (step1) begin
          nxt_timer1Low = lowSum[8] ? timer1_count_high_ff : lowSum[7:0];
          overflow1     = lowSum[8];
        end
      end
      // Mode 3 stops Timer1; both bytes keep the values set above.
      default: nxt_timer1Low = timer1_count_low_ff;
    endcase
  end

  // ==========================================================================
  // Flag set events.
  logic        setFlag0;
  logic        setFlag1;
  logic        setEdge0;
  logic        setEdge1;

  assign setFlag0 = overflow0;
  // While Timer0 is split, its high byte owns the Timer1 flag.
  assign setFlag1 = (mode0 == MODE_SPLIT) ? overflowSplit : overflow1;
  assign setEdge0 = ext_ext_interrupt0_pin_trigger_select_ff & pinFall[2];
  assign setEdge1 = ext_ext_interrupt1_pin_trigger_select_ff & pinFall[3];

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY.
  logic        busWrite_ff;
  logic [29:0] busIndex_ff;
  logic        addrPhase;
  logic [7:0]  wrByte;
  logic [7:0]  readByte;
  logic [7:0]  runFlags;

  assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign wrByte    = hwdata[7:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busWrite_ff <= 1'b0;
      busIndex_ff <= 30'h0;
    end else begin
      busWrite_ff <= addrPhase & hwrite;
      busIndex_ff <= haddr[31:2];
    end
  end

  function automatic logic wrHit(input logic [29:0] idx);
    wrHit = busWrite_ff & hitIndex(busIndex_ff, idx);
  endfunction

  assign runFlags = {timer1_overflow_flag_ff, timer1_run_ff,
                     timer0_overflow_flag_ff, timer0_run_ff,
                     ext_ext_interrupt1_pin_edge_flag_ff, ext_ext_interrupt1_pin_trigger_select_ff,
                     ext_ext_interrupt0_pin_edge_flag_ff, ext_ext_interrupt0_pin_trigger_select_ff};

  always_comb begin
    case (haddr[31:2])
      IDX_RUN_FLAGS: readByte = runFlags;
      IDX_MODE_SEL:  readByte = timer_mode_select_ff;
      IDX_T0_LOW:    readByte = timer0_count_low_ff;
      IDX_T1_LOW:    readByte = timer1_count_low_ff;
      IDX_T0_HIGH:   readByte = timer0_count_high_ff;
      IDX_T1_HIGH:   readByte = timer1_count_high_ff;
      default:       readByte = RST_BYTE;
    endcase
  end

  // Read data is taken at the address phase; a write still in its data phase
  // to the same register is forwarded, so no stale byte is handed back.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (addrPhase && !hwrite) begin
      hrdata <= {24'h0, (wrHit(haddr[31:2]) ? wrByte : readByte)};
    end
  end

  // ==========================================================================
  // Run and trigger control bits.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer1_run_ff              <= 1'b0;
      timer0_run_ff              <= 1'b0;
      ext_ext_interrupt1_pin_trigger_select_ff <= 1'b0;
      ext_ext_interrupt0_pin_trigger_select_ff <= 1'b0;
    end else if (wrHit(IDX_RUN_FLAGS)) begin
      timer1_run_ff              <= wrByte[BIT_T1_RUN];
      timer0_run_ff              <= wrByte[BIT_T0_RUN];
      ext_ext_interrupt1_pin_trigger_select_ff <= wrByte[BIT_X1_TRIG];
      ext_ext_interrupt0_pin_trigger_select_ff <= wrByte[BIT_X0_TRIG];
    end
  end

  // ==========================================================================
  // Sticky flags: a hardware set in the same cycle beats any clear.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer1_overflow_flag_ff <= 1'b0;
      timer0_overflow_flag_ff <= 1'b0;
      ext_ext_interrupt1_pin_edge_flag_ff   <= 1'b0;
      ext_ext_interrupt0_pin_edge_flag_ff   <= 1'b0;
    end else if (wrHit(IDX_RUN_FLAGS)) begin
      timer1_overflow_flag_ff <= setFlag1 | wrByte[BIT_T1_OVF];
      timer0_overflow_flag_ff <= setFlag0 | wrByte[BIT_T0_OVF];
      ext_ext_interrupt1_pin_edge_flag_ff   <= setEdge1 | wrByte[BIT_X1_EDGE];
      ext_ext_interrupt0_pin_edge_flag_ff   <= setEdge0 | wrByte[BIT_X0_EDGE];
    end else begin
      timer1_overflow_flag_ff <= setFlag1 | (timer1_overflow_flag_ff & ~timer1VectorAck);
      timer0_overflow_flag_ff <= setFlag0 | (timer0_overflow_flag_ff & ~timer0VectorAck);
      ext_ext_interrupt1_pin_edge_flag_ff   <= setEdge1 | (ext_ext_interrupt1_pin_edge_flag_ff & ~extInt1VectorAck);
      ext_ext_interrupt0_pin_edge_flag_ff   <= setEdge0 | (ext_ext_interrupt0_pin_edge_flag_ff & ~extInt0VectorAck);
    end
  end

  // ==========================================================================
  // Mode select register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_mode_select_ff <= RST_BYTE;
    end else if (wrHit(IDX_MODE_SEL)) begin
      timer_mode_select_ff <= wrByte;
    end
  end

  // ==========================================================================
  // Count bytes: a software write wins over a count in the same cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer0_count_low_ff  <= RST_BYTE;
      timer0_count_high_ff <= RST_BYTE;
      timer1_count_low_ff  <= RST_BYTE;
      timer1_count_high_ff <= RST_BYTE;
    end else begin
      timer0_count_low_ff  <= wrHit(IDX_T0_LOW) ? wrByte : nxt_timer0Low;
      timer0_count_high_ff <= wrHit(IDX_T0_HIGH) ? wrByte : nxt_timer0High;
      timer1_count_low_ff  <= wrHit(IDX_T1_LOW) ? wrByte : nxt_timer1Low;
      timer1_count_high_ff <= wrHit(IDX_T1_HIGH) ? wrByte : nxt_timer1High;
    end
  end

  // ==========================================================================
  // Interrupt requests; in level mode the synchronised low pin asks directly.
  assign timer0IntRequest  = timer0_overflow_flag_ff;
  assign timer1IntRequest  = timer1_overflow_flag_ff;
  assign extInt0IntRequest = ext_ext_interrupt0_pin_trigger_select_ff ? ext_ext_interrupt0_pin_edge_flag_ff
                                                        : ~pinSync_ff[2];
  assign extInt1IntRequest = ext_ext_interrupt1_pin_trigger_select_ff ? ext_ext_interrupt1_pin_edge_flag_ff
                                                        : ~pinSync_ff[3];

endmodule

// >>> dual_timer_pkg.sv
// Package of register map, field layout and timing constants for the dual timer block.
package dual_timer_pkg;

  // ==========================================================================
  // Register indices; the byte address of a register is four times its index.
  localparam logic [29:0] IDX_RUN_FLAGS  = 30'h88;
  localparam logic [29:0] IDX_MODE_SEL   = 30'h89;
  localparam logic [29:0] IDX_T0_LOW     = 30'h8a;
  localparam logic [29:0] IDX_T1_LOW     = 30'h8b;
  localparam logic [29:0] IDX_T0_HIGH    = 30'h8c;
  localparam logic [29:0] IDX_T1_HIGH    = 30'h8d;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [1:0]  RST_MODE       = 2'h0;

  // ==========================================================================
  // Bit positions in the run and flag register.
  localparam int          BIT_T1_OVF     = 7;
  localparam int          BIT_T1_RUN     = 6;
  localparam int          BIT_T0_OVF     = 5;
  localparam int          BIT_T0_RUN     = 4;
  localparam int          BIT_X1_EDGE    = 3;
  localparam int          BIT_X1_TRIG    = 2;
  localparam int          BIT_X0_EDGE    = 1;
  localparam int          BIT_X0_TRIG    = 0;

  // ==========================================================================
  // Bit positions in the mode select register.
  localparam int          BIT_T1_GATE    = 7;
  localparam int          BIT_T1_CNT     = 6;
  localparam int          MSB_T1_MODE    = 5;
  localparam int          LSB_T1_MODE    = 4;
  localparam int          BIT_T0_GATE    = 3;
  localparam int          BIT_T0_CNT     = 2;
  localparam int          MSB_T0_MODE    = 1;
  localparam int          LSB_T0_MODE    = 0;

  // ==========================================================================
  // Timer modes.
  typedef enum logic [1:0] {
    MODE_PRESCALED = 2'h0,
    MODE_WIDE16    = 2'h1,
    MODE_RELOAD8   = 2'h2,
    MODE_SPLIT     = 2'h3
  } timer_mode_t;

  // ==========================================================================
  // Prescaler width in the 13-bit mode and the last divider phase of the two-clock timer tick.
  localparam int          PRESCALE_BITS  = 5;
  localparam logic [0:0]  TICK_LAST      = 1'h1;

  // ==========================================================================
  // Bus encodings.
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic        HRESP_OKAY     = 1'h0;

endpackage

// >>> dual_timer_chk.sv
// Assertion checker for the dual timer block, bound to its top module.
`timescale 1ns/1ps
module dual_timer_chk (
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register bus.
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pins and interrupt side.
  input wire logic        extInterrupt0Pin,
  input wire logic        extInterrupt1Pin,
  input wire logic        timer0VectorAck,
  input wire logic        timer1VectorAck,
  input wire logic        extInt0VectorAck,
  input wire logic        timer0IntRequest,
  input wire logic        timer1IntRequest,
  input wire logic        extInt0IntRequest,
  input wire logic        extInt1IntRequest
);
  import dual_timer_pkg::*;
  // ==========================================================================
  // Shadow of the control bits that only software writes can change.
  logic        wrPend_ff;
  logic [29:0] wrIdx_ff;
  logic [7:0]  ctl_ff;
  logic        wrFlags;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_ff <= 1'b0;
      wrIdx_ff  <= 30'h0;
    end else if (hready) begin
      wrPend_ff <= hsel && htrans == HTRANS_NONSEQ && hwrite;
      wrIdx_ff  <= haddr[31:2];
    end
  end
  assign wrFlags = wrPend_ff && hready && wrIdx_ff == IDX_RUN_FLAGS;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= 8'h00;
    end else if (wrFlags) begin
      ctl_ff <= hwdata[7:0];
    end
  end
  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_bus_always_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
    else $error("bus answer not a zero-wait okay byte");
  a_lvl0_follows_pin: assert property (!ctl_ff[BIT_X0_TRIG] |->
    extInt0IntRequest == !$past(extInterrupt0Pin, 2)) else $error("level request 0 wrong");
  a_lvl1_follows_pin: assert property (!ctl_ff[BIT_X1_TRIG] |->
    extInt1IntRequest == !$past(extInterrupt1Pin, 2)) else $error("level request 1 wrong");
  a_edge0_ack_clears: assert property (ctl_ff[BIT_X0_TRIG] && extInt0VectorAck && !wrFlags
    && extInterrupt0Pin && $past(extInterrupt0Pin) && $past(extInterrupt0Pin, 2)
    && $past(extInterrupt0Pin, 3) |=> !extInt0IntRequest) else $error("edge flag 0 kept");
  a_edge1_sets_flag: assert property (ctl_ff[BIT_X1_TRIG] && !wrFlags
    && $past(extInterrupt1Pin, 3) && !$past(extInterrupt1Pin, 2) |-> ##[1:2] extInt1IntRequest)
    else $error("edge flag 1 not set");
  a_t0_idle_quiet: assert property (!ctl_ff[BIT_T0_RUN] && !wrFlags |=>
    !$rose(timer0IntRequest)) else $error("stopped timer0 raised its flag");
  a_t1_idle_quiet: assert property (!ctl_ff[BIT_T1_RUN] && !wrFlags |=>
    !$rose(timer1IntRequest)) else $error("stopped timer1 raised its flag");
  a_t0_ack_clears: assert property (timer0VectorAck && !ctl_ff[BIT_T0_RUN] && !wrFlags
    |=> !timer0IntRequest) else $error("timer0 flag kept after acknowledge");
  a_t1_ack_clears: assert property (timer1VectorAck && !ctl_ff[BIT_T1_RUN] && !wrFlags
    |=> !timer1IntRequest) else $error("timer1 flag kept after acknowledge");
endmodule

bind dual_timer dual_timer_chk ruleWatch (
  .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .extInterrupt0Pin(extInterrupt0Pin), .extInterrupt1Pin(extInterrupt1Pin),
  .timer0VectorAck(timer0VectorAck), .timer1VectorAck(timer1VectorAck),
  .extInt0VectorAck(extInt0VectorAck), .timer0IntRequest(timer0IntRequest),
  .timer1IntRequest(timer1IntRequest), .extInt0IntRequest(extInt0IntRequest),
  .extInt1IntRequest(extInt1IntRequest));

// >>> ext_side_model.sv
// Model of the pins and the CPU interrupt logic that face the dual timer block.
`timescale 1ns/1ps
module ext_side_model (
  // Clock.
  input  wire logic       mclk,
  // Pins: 0 timer0 count, 1 timer1 count, 2 interrupt 0, 3 interrupt 1.
  output logic      [3:0] pinLvl,
  // Vector acknowledges: 0 timer0, 1 timer1, 2 interrupt 0, 3 interrupt 1.
  output logic      [3:0] ackPulse
);
  initial begin
    pinLvl   = 4'hf;
    ackPulse = 4'h0;
  end
  // Each level is held four clocks so that the synchroniser cannot miss it.
  task automatic fall_pin(input int n);
    @(posedge mclk);
    pinLvl[n] <= 1'b0;
    repeat (4) @(posedge mclk);
    pinLvl[n] <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  task automatic set_pin(input int n, input logic v);
    @(posedge mclk);
    pinLvl[n] <= v;
  endtask
  task automatic ack(input int n);
    @(posedge mclk);
    ackPulse[n] <= 1'b1;
    @(posedge mclk);
    ackPulse[n] <= 1'b0;
  endtask
endmodule

// >>> testbench.sv
// Self-checking testbench for the dual timer block.
`timescale 1ns/1ps
module testbench;
  import dual_timer_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [3:0]  pinLvl;
  logic [3:0]  ackPulse;
  logic [3:0]  irq;
  logic [31:0] rd;
  logic [31:0] keep;
  int          errors;
  int          checkCount;
  int          n;

  dual_timer DUT (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer0CountPin(pinLvl[0]), .timer1CountPin(pinLvl[1]),
    .extInterrupt0Pin(pinLvl[2]), .extInterrupt1Pin(pinLvl[3]),
    .timer0VectorAck(ackPulse[0]), .timer1VectorAck(ackPulse[1]),
    .extInt0VectorAck(ackPulse[2]), .extInt1VectorAck(ackPulse[3]),
    .timer0IntRequest(irq[0]), .timer1IntRequest(irq[1]),
    .extInt0IntRequest(irq[2]), .extInt1IntRequest(irq[3]));
  ext_side_model farSide (.mclk(mclk), .pinLvl(pinLvl), .ackPulse(ackPulse));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================================
  // Bus and comparison tasks.
  task automatic bus(input logic wr, input logic [29:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {idx, 2'b00};
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= {24'h0, wd};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [29:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic waitc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize;
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    rst_n      = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0;
    errors     = 0;
    checkCount = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (n = 0; n < 6; n++) rdchk(IDX_RUN_FLAGS + 30'(n), 8'h00);
    for (n = 1; n < 6; n++) begin
      bus(1'b1, IDX_RUN_FLAGS + 30'(n), 8'ha0 + 8'(n));
      rdchk(IDX_RUN_FLAGS + 30'(n), 8'ha0 + 8'(n));
    end
    bus(1'b1, 30'hc0, 8'h5a);
    rdchk(30'hc0, 8'h00);
    // Sixteen-bit timer from fff0: no overflow before sixteen ticks of two clocks.
    bus(1'b1, IDX_MODE_SEL, 8'h01);
    bus(1'b1, IDX_T0_LOW, 8'hf0);
    bus(1'b1, IDX_T0_HIGH, 8'hff);
    bus(1'b1, IDX_RUN_FLAGS, 8'h10);
    waitc(20);
    chk(32'(irq[0]), 32'h0);
    waitc(20);
    chk(32'(irq[0]), 32'h1);
    bus(1'b1, IDX_RUN_FLAGS, 8'h20);
    farSide.ack(0);
    waitc(1);
    chk(32'(irq[0]), 32'h0);
    bus(1'b0, IDX_T0_LOW, 8'h00);
    keep = rd;
    waitc(10);
    rdchk(IDX_T0_LOW, keep[7:0]);
    // Auto-reload keeps the low byte between fc and ff.
    bus(1'b1, IDX_MODE_SEL, 8'h02);
    bus(1'b1, IDX_T0_HIGH, 8'hfc);
    bus(1'b1, IDX_T0_LOW, 8'hfc);
    bus(1'b1, IDX_RUN_FLAGS, 8'h10);
    waitc(20);
    chk(32'(irq[0]), 32'h1);
    bus(1'b1, IDX_RUN_FLAGS, 8'h00);
    bus(1'b0, IDX_T0_LOW, 8'h00);
    chk(32'(rd[7:2]), 32'h3f);
    rdchk(IDX_T0_HIGH, 8'hfc);
    // Prescaled mode: the five-bit prescaler carries into the high byte.
    bus(1'b1, IDX_MODE_SEL, 8'h00);
    bus(1'b1, IDX_T1_LOW, 8'hfe);
    bus(1'b1, IDX_T1_HIGH, 8'hff);
    bus(1'b1, IDX_RUN_FLAGS, 8'h40);
    waitc(12);
    chk(32'(irq[1]), 32'h1);
    bus(1'b1, IDX_RUN_FLAGS, 8'h80);
    farSide.ack(1);
    waitc(1);
    chk(32'(irq[1]), 32'h0);
    bus(1'b0, IDX_T1_LOW, 8'h00);
    chk(32'(rd[7:5]), 32'h7);
    rdchk(IDX_T1_HIGH, 8'h00);
    bus(1'b1, IDX_MODE_SEL, 8'h30);
    bus(1'b1, IDX_RUN_FLAGS, 8'h40);
    waitc(10);
    bus(1'b1, IDX_RUN_FLAGS, 8'h00);
    rdchk(IDX_T1_HIGH, 8'h00);
    // Counter mode counts pin falls only, each exactly once.
    bus(1'b1, IDX_MODE_SEL, 8'h05);
    bus(1'b1, IDX_T0_LOW, 8'h00);
    bus(1'b1, IDX_RUN_FLAGS, 8'h10);
    for (n = 0; n < 3; n++) farSide.fall_pin(0);
    rdchk(IDX_T0_LOW, 8'h03);
    // Gated timer waits for the interrupt-0 pin, which is low before the gate is set.
    farSide.set_pin(2, 1'b0);
    bus(1'b1, IDX_MODE_SEL, 8'h09);
    bus(1'b1, IDX_T0_LOW, 8'h00);
    waitc(10);
    rdchk(IDX_T0_LOW, 8'h00);
    farSide.set_pin(2, 1'b1);
    waitc(10);
    bus(1'b1, IDX_RUN_FLAGS, 8'h00);
    bus(1'b0, IDX_T0_LOW, 8'h00);
    chk(32'(rd[7:0] != 8'h00), 32'h1);
    // Split mode: timer1 wraps without a flag; timer0 high byte owns it.
    bus(1'b1, IDX_MODE_SEL, 8'h13);
    bus(1'b1, IDX_T1_LOW, 8'hfc);
    bus(1'b1, IDX_T1_HIGH, 8'hff);
    bus(1'b1, IDX_T0_HIGH, 8'h00);
    bus(1'b1, IDX_RUN_FLAGS, 8'h40);
    waitc(20);
    chk(32'(irq[1]), 32'h0);
    bus(1'b1, IDX_T0_HIGH, 8'hff);
    waitc(8);
    chk(32'(irq[1]), 32'h1);
    bus(1'b1, IDX_RUN_FLAGS, 8'h00);
    // Timer1 reload counts pin falls, gated by the interrupt-1 pin.
    bus(1'b1, IDX_MODE_SEL, 8'he0);
    bus(1'b1, IDX_T1_HIGH, 8'hfe);
    bus(1'b1, IDX_T1_LOW, 8'hfe);
    bus(1'b1, IDX_RUN_FLAGS, 8'h40);
    for (n = 0; n < 2; n++) farSide.fall_pin(1);
    chk(32'(irq[1]), 32'h1);
    rdchk(IDX_T1_LOW, 8'hfe);
    farSide.set_pin(3, 1'b0);
    farSide.fall_pin(1);
    farSide.set_pin(3, 1'b1);
    rdchk(IDX_T1_LOW, 8'hfe);
    bus(1'b1, IDX_RUN_FLAGS, 8'h00);
    // External interrupts in edge mode, then in level mode.
    for (n = 0; n < 2; n++) begin
      bus(1'b1, IDX_RUN_FLAGS, 8'h01 << (2 * n));
      farSide.fall_pin(2 + n);
      chk(32'(irq[2 + n]), 32'h1);
      rdchk(IDX_RUN_FLAGS, 8'h03 << (2 * n));
      farSide.ack(2 + n);
      waitc(1);
      chk(32'(irq[2 + n]), 32'h0);
      bus(1'b1, IDX_RUN_FLAGS, 8'h00);
      farSide.set_pin(2 + n, 1'b0);
      waitc(3);
      chk(32'(irq[2 + n]), 32'h1);
      farSide.set_pin(2 + n, 1'b1);
      waitc(3);
      chk(32'(irq[2 + n]), 32'h0);
    end
    summarize;
  end
endmodule
